// >>> design/mas_pkg.sv
// Register map, field layout, reset values and carriers of the serial port
package mas_pkg;
    localparam logic [4:0] ADDR_STATUS = 5'h00;
    localparam logic [4:0] ADDR_CONTROL = 5'h01;
    localparam logic [4:0] ADDR_UPPER = 5'h02;
    localparam logic [4:0] ADDR_LOWER = 5'h03;
    localparam logic [4:0] ADDR_SEG1 = 5'h04;
    localparam logic [4:0] ADDR_SEG2 = 5'h05;
    localparam logic [4:0] ADDR_SEG3 = 5'h06;
    localparam logic [4:0] ADDR_OFFSET = 5'h07;
    localparam logic [4:0] ADDR_RESULT_HIGH = 5'h08;
    localparam logic [4:0] ADDR_DISPLAY = 5'h09;
    localparam logic [4:0] ADDR_PEAK = 5'h0A;
    localparam logic [4:0] ADDR_RESULT_LOW = 5'h14;

    // Command byte fields
    localparam int CMD_RW_BIT = 6;
    localparam int CMD_ADDR_MSB = 5;
    localparam int CMD_ADDR_LSB = 1;
    // Control register clear-all bit
    localparam int CTRL_CLEAR_BIT = 4;

    // Bit counter end values on the link
    localparam logic [4:0] ADDR_KNOWN = 5'h06;
    localparam logic [4:0] CMD_LAST = 5'h07;
    localparam logic [4:0] NARROW_LAST = 5'h07;
    localparam logic [4:0] WIDE_LAST = 5'h0F;
    localparam logic [5:0] ZERO_RUN = 6'h20;

    // Power-on values
    localparam logic [15:0] CTRL_RST = 16'h0001;
    localparam logic [15:0] UPPER_RST = 16'h4E1F;
    localparam logic [15:0] LOWER_RST = 16'hB1E0;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [7:0] BYTE_RST = 8'h00;

    // Conversion period
    localparam int SYS_CLK_HZ = 100_000_000;
    localparam int ADC_REF_CLK_HZ = 4_915_200;
    localparam int EOC_PERIOD_MS = 200;
    localparam int EOC_PERIOD_CYC = EOC_PERIOD_MS * (SYS_CLK_HZ / 1000);

    typedef struct packed {
        logic sign;
        logic over;
        logic under;
        logic battery_sense_in;
        logic ready;
    } mas_flags_t;

    typedef struct packed {
        logic [4:0] addr;
        logic [15:0] data;
    } mas_evt_t;

    typedef enum logic [2:0] {
        L_IDLE = 3'b001,
        L_CMD = 3'b010,
        L_DATA = 3'b100
    } mas_link_t;

    function automatic logic regIsWide(input logic [4:0] a);
        return !(a == ADDR_STATUS || a == ADDR_SEG3 || a > ADDR_PEAK);
    endfunction

    function automatic logic regIsWritable(input logic [4:0] a);
        return a >= ADDR_CONTROL && a <= ADDR_DISPLAY
            && a != ADDR_RESULT_HIGH;
    endfunction
endpackage

// >>> design/mas_sync2.sv
// Two-flop synchroniser for levels and toggles
`timescale 1ns/100ps
module mas_sync2
#(
    parameter int W = 1
)
(
    input wire logic clk,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk)
    begin
        meta_q <= d;
        q <= meta_q;
    end
endmodule

// >>> design/mas_serial_port.sv
// Serial register port of the meter converter: link side and registers
//
// Behaviour
// - Chip select high floats data out and ignores clock and data in.
// - Data in sampled on rising clock, data out shifted on falling clock.
// - Command and data travel MSB first, data left justified.
// - Idle ignores zeros; first one starts command; seven more bits follow.
// - Command bit 6 one reads, zero writes the addressed register.
// - Command bits 5..1 give register address; bit 0 ignored.
// - Data phase is exactly register width, 8 or 16, then idle.
// - Writes to read-only registers are discarded.
// - Thirty-two consecutive zeros reset framing to await a command.
// - Twelve registers decoded at 00000..01010 and 10100; rest reserved.
// - End-of-conversion pulses each period; results update while it is high.
// - Result high holds upper sixteen bits, result low lowest four.
// - Status is 8-bit, resets 00h, five flags, low three bits zero.
// - Sign flag latches on negative result; status read clears if positive.
// - Overrange latches above upper limit; status read clears unless still.
// - Underrange latches below lower limit; status read clears unless still.
// - Low-battery latches while battery sense input is high; clears on read once ended.
// - Ready flag latches per conversion; cleared by result high read only.
// - Clear-all bit resets every register at next chip select rise.
`timescale 1ns/100ps
module mas_serial_port
#(
    parameter int EocPeriodCyc = mas_pkg::EOC_PERIOD_CYC,
    parameter bit BattMonitor = 1'b1
)
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic spiClk,
    input wire logic csN,
    input wire logic mosi,
    output logic dout,
    output logic doutOe,
    output logic eocN,
    input wire logic [19:0] convSample,
    input wire logic batterySenseIn,
    output logic [15:0] controlOut
);
    import mas_pkg::*;

    localparam logic [24:0] EocLast = 25'(EocPeriodCyc - 1);

    // Link side, serial clock domain
    logic rstLink;
    mas_link_t state_q, state_d;
    logic [4:0] bitCnt_q, bitCnt_d;
    logic [6:0] cmd_q, cmd_d;
    logic [15:0] rx_q, rx_d;
    logic [5:0] zeroCnt_q, zeroCnt_d;
    logic cmdTgl_q, cmdTgl_d, wrTgl_q, wrTgl_d, doneTgl_q, doneTgl_d;
    mas_evt_t evt_q, evt_d;
    logic [15:0] tx_q, tx_d;
    logic dout_q, dout_d;
    logic [7:0] cmdByte;
    logic isRead;
    logic [4:0] cmdAddr;
    logic [4:0] lastBit;
    logic [15:0] rxWord;

    // Register side, system clock domain
    logic [4:0] syncIn, syncOut;
    logic [2:0] tglSeen_q;
    logic csSeen_q;
    logic cmdEvt, wrEvt, doneEvt, csRise, battLow;
    logic [15:0] readWord_q, readWord_d, rdVal;
    logic [15:0] control_q, control_d, upper_q, upper_d, lower_q, lower_d;
    logic [15:0] seg1_q, seg1_d, seg2_q, seg2_d, offset_q, offset_d;
    logic [15:0] resHigh_q, resHigh_d, display_q, display_d;
    logic [15:0] peak_q, peak_d;
    logic [7:0] seg3_q, seg3_d, resLow_q, resLow_d;
    mas_flags_t flags_q, flags_d, setF, stillF;
    logic clrPend_q, clrPend_d;
    logic [24:0] eocCnt_q, eocCnt_d;
    logic eocHigh_q, eocHigh_d;
    logic statusDone;

    mas_sync2 #(.W(1)) uLinkRst
    (
        .clk(spiClk),
        .d(srst),
        .q(rstLink)
    );

    assign cmdByte = {cmd_q, 1'b0};
    assign isRead = cmdByte[CMD_RW_BIT];
    assign cmdAddr = cmdByte[CMD_ADDR_MSB:CMD_ADDR_LSB];
    assign lastBit = regIsWide(cmdAddr) ? WIDE_LAST : NARROW_LAST;
    assign rxWord = {rx_q[14:0], mosi};

    // Rising edge: framing, command and receive shift
    always_comb
    begin
        state_d = state_q;
        bitCnt_d = bitCnt_q;
        cmd_d = cmd_q;
        rx_d = rx_q;
        zeroCnt_d = zeroCnt_q;
        cmdTgl_d = cmdTgl_q;
        wrTgl_d = wrTgl_q;
        doneTgl_d = doneTgl_q;
        evt_d = evt_q;
        if (!csN)
        begin
            zeroCnt_d = mosi ? 6'h00 : zeroCnt_q + 6'h01;
            if (!mosi && zeroCnt_q == ZERO_RUN - 6'h01)
            begin
                zeroCnt_d = 6'h00;
                state_d = L_IDLE;
                bitCnt_d = 5'h00;
            end
            else
            begin
                unique case (state_q)
                    L_IDLE:
                    begin
                        if (mosi)
                        begin
                            state_d = L_CMD;
                            cmd_d = 7'h01;
                            bitCnt_d = 5'h01;
                        end
                    end
                    L_CMD:
                    begin
                        bitCnt_d = bitCnt_q + 5'h01;
                        if (bitCnt_q == ADDR_KNOWN)
                        begin
                            cmd_d = {cmd_q[5:0], mosi};
                            cmdTgl_d = ~cmdTgl_q;
                        end
                        else if (bitCnt_q == CMD_LAST)
                        begin
                            state_d = L_DATA;
                            bitCnt_d = 5'h00;
                        end
                        else
                        begin
                            cmd_d = {cmd_q[5:0], mosi};
                        end
                    end
                    L_DATA:
                    begin
                        rx_d = rxWord;
                        bitCnt_d = bitCnt_q + 5'h01;
                        if (bitCnt_q == lastBit)
                        begin
                            state_d = L_IDLE;
                            bitCnt_d = 5'h00;
                            evt_d.addr = cmdAddr;
                            evt_d.data = regIsWide(cmdAddr) ? rxWord
                                : {BYTE_RST, rxWord[7:0]};
                            if (isRead)
                                doneTgl_d = ~doneTgl_q;
                            else
                                wrTgl_d = ~wrTgl_q;
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge spiClk)
    begin
        if (rstLink)
        begin
            state_q <= L_IDLE;
            bitCnt_q <= 5'h00;
            cmd_q <= 7'h00;
            rx_q <= WORD_RST;
            zeroCnt_q <= 6'h00;
            cmdTgl_q <= 1'b0;
            wrTgl_q <= 1'b0;
            doneTgl_q <= 1'b0;
            evt_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            bitCnt_q <= bitCnt_d;
            cmd_q <= cmd_d;
            rx_q <= rx_d;
            zeroCnt_q <= zeroCnt_d;
            cmdTgl_q <= cmdTgl_d;
            wrTgl_q <= wrTgl_d;
            doneTgl_q <= doneTgl_d;
            evt_q <= evt_d;
        end
    end

    // Falling edge: transmit shift, loaded from the held read word
    always_comb
    begin
        tx_d = tx_q;
        dout_d = dout_q;
        if (!csN)
        begin
            if (state_q == L_DATA && isRead && bitCnt_q == 5'h00)
            begin
                dout_d = readWord_q[15];
                tx_d = {readWord_q[14:0], 1'b0};
            end
            else if (state_q == L_DATA && isRead)
            begin
                dout_d = tx_q[15];
                tx_d = {tx_q[14:0], 1'b0};
            end
            else
            begin
                dout_d = 1'b0;
            end
        end
    end

    always_ff @(negedge spiClk)
    begin
        if (rstLink)
        begin
            tx_q <= WORD_RST;
            dout_q <= 1'b0;
        end
        else
        begin
            tx_q <= tx_d;
            dout_q <= dout_d;
        end
    end

    assign dout = dout_q;
    assign doutOe = ~csN;

    // Events from the link reach the register side as toggles
    assign syncIn = {cmdTgl_q, wrTgl_q, doneTgl_q, csN, batterySenseIn};
    mas_sync2 #(.W(5)) uSysSync
    (
        .clk(sys_clk),
        .d(syncIn),
        .q(syncOut)
    );
    assign cmdEvt = syncOut[4] ^ tglSeen_q[2];
    assign wrEvt = syncOut[3] ^ tglSeen_q[1];
    assign doneEvt = syncOut[2] ^ tglSeen_q[0];
    assign csRise = syncOut[1] & ~csSeen_q;
    assign battLow = syncOut[0] & BattMonitor;
    assign statusDone = doneEvt && evt_q.addr == ADDR_STATUS;

    // Register file, conversion timing and flags
    always_comb
    begin
        readWord_d = readWord_q;
        control_d = control_q;
        upper_d = upper_q;
        lower_d = lower_q;
        seg1_d = seg1_q;
        seg2_d = seg2_q;
        seg3_d = seg3_q;
        offset_d = offset_q;
        resHigh_d = resHigh_q;
        display_d = display_q;
        peak_d = peak_q;
        resLow_d = resLow_q;
        clrPend_d = clrPend_q;
        eocCnt_d = eocCnt_q + 25'h000_0001;
        eocHigh_d = 1'b0;
        if (eocCnt_q == EocLast)
        begin
            eocCnt_d = 25'h000_0000;
            eocHigh_d = 1'b1;
        end

        case (cmdAddr)
            ADDR_STATUS: rdVal = {flags_q, 3'h0, BYTE_RST};
            ADDR_CONTROL: rdVal = control_q;
            ADDR_UPPER: rdVal = upper_q;
            ADDR_LOWER: rdVal = lower_q;
            ADDR_SEG1: rdVal = seg1_q;
            ADDR_SEG2: rdVal = seg2_q;
            ADDR_SEG3: rdVal = {seg3_q, BYTE_RST};
            ADDR_OFFSET: rdVal = offset_q;
            ADDR_RESULT_HIGH: rdVal = resHigh_q;
            ADDR_DISPLAY: rdVal = display_q;
            ADDR_PEAK: rdVal = peak_q;
            ADDR_RESULT_LOW: rdVal = {resLow_q, BYTE_RST};
            default: rdVal = WORD_RST;
        endcase
        if (cmdEvt)
            readWord_d = rdVal;

        setF.sign = eocHigh_q & convSample[19];
        setF.over = eocHigh_q
            & ($signed(convSample[19:4]) > $signed(upper_q));
        setF.under = eocHigh_q
            & ($signed(convSample[19:4]) < $signed(lower_q));
        setF.battery_sense_in = battLow;
        setF.ready = eocHigh_q;
        stillF.sign = resHigh_q[15];
        stillF.over = $signed(resHigh_q) > $signed(upper_q);
        stillF.under = $signed(resHigh_q) < $signed(lower_q);
        stillF.battery_sense_in = battLow;
        stillF.ready = 1'b0;
        flags_d = flags_q | setF;
        if (statusDone)
        begin
            flags_d.sign = stillF.sign | setF.sign;
            flags_d.over = stillF.over | setF.over;
            flags_d.under = stillF.under | setF.under;
            flags_d.battery_sense_in = stillF.battery_sense_in;
        end
        if (doneEvt && evt_q.addr == ADDR_RESULT_HIGH)
            flags_d.ready = setF.ready;

        if (eocHigh_q)
        begin
            resHigh_d = convSample[19:4];
            resLow_d = {4'h0, convSample[3:0]};
            if ($signed(convSample[19:4]) > $signed(peak_q))
                peak_d = convSample[19:4];
        end

        if (wrEvt && regIsWritable(evt_q.addr))
        begin
            case (evt_q.addr)
                ADDR_CONTROL:
                begin
                    control_d = evt_q.data;
                    clrPend_d = evt_q.data[CTRL_CLEAR_BIT];
                end
                ADDR_UPPER: upper_d = evt_q.data;
                ADDR_LOWER: lower_d = evt_q.data;
                ADDR_SEG1: seg1_d = evt_q.data;
                ADDR_SEG2: seg2_d = evt_q.data;
                ADDR_SEG3: seg3_d = evt_q.data[7:0];
                ADDR_OFFSET: offset_d = evt_q.data;
                ADDR_DISPLAY: display_d = evt_q.data;
                default: clrPend_d = clrPend_q;
            endcase
        end

        if (csRise && clrPend_q)
        begin
            control_d = CTRL_RST;
            upper_d = UPPER_RST;
            lower_d = LOWER_RST;
            seg1_d = WORD_RST;
            seg2_d = WORD_RST;
            seg3_d = BYTE_RST;
            offset_d = WORD_RST;
            resHigh_d = WORD_RST;
            display_d = WORD_RST;
            peak_d = WORD_RST;
            resLow_d = BYTE_RST;
            flags_d = '0;
            clrPend_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            tglSeen_q <= 3'h0;
            csSeen_q <= 1'b1;
            readWord_q <= WORD_RST;
            control_q <= CTRL_RST;
            upper_q <= UPPER_RST;
            lower_q <= LOWER_RST;
            seg1_q <= WORD_RST;
            seg2_q <= WORD_RST;
            seg3_q <= BYTE_RST;
            offset_q <= WORD_RST;
            resHigh_q <= WORD_RST;
            display_q <= WORD_RST;
            peak_q <= WORD_RST;
            resLow_q <= BYTE_RST;
            flags_q <= '0;
            clrPend_q <= 1'b0;
            eocCnt_q <= 25'h000_0000;
            eocHigh_q <= 1'b0;
        end
        else
        begin
            tglSeen_q <= syncOut[4:2];
            csSeen_q <= syncOut[1];
            readWord_q <= readWord_d;
            control_q <= control_d;
            upper_q <= upper_d;
            lower_q <= lower_d;
            seg1_q <= seg1_d;
            seg2_q <= seg2_d;
            seg3_q <= seg3_d;
            offset_q <= offset_d;
            resHigh_q <= resHigh_d;
            display_q <= display_d;
            peak_q <= peak_d;
            resLow_q <= resLow_d;
            flags_q <= flags_d;
            clrPend_q <= clrPend_d;
            eocCnt_q <= eocCnt_d;
            eocHigh_q <= eocHigh_d;
        end
    end

    assign eocN = eocHigh_q;
    assign controlOut = control_q;

    // Link checks
    property p_csIgnore;
        @(posedge spiClk) disable iff (rstLink)
        csN |=> $stable(state_q) && $stable(bitCnt_q);
    endproperty
    a_csIgnore: assert property (p_csIgnore) else $error("moved under cs");

    property p_idleZero;
        @(posedge spiClk) disable iff (rstLink)
        state_q == L_IDLE && !csN && !mosi |=> state_q == L_IDLE;
    endproperty
    a_idleZero: assert property (p_idleZero) else $error("zero left idle");

    property p_cmdLen;
        @(posedge spiClk) disable iff (rstLink)
        state_q == L_IDLE && !csN && mosi ##1 !csN [*7]
            |=> state_q == L_DATA && bitCnt_q == 5'h00;
    endproperty
    a_cmdLen: assert property (p_cmdLen) else $error("command length");

    property p_dataEnd;
        @(posedge spiClk) disable iff (rstLink)
        state_q == L_DATA && !csN && bitCnt_q == lastBit
            && zeroCnt_q != ZERO_RUN - 6'h01 |=> state_q == L_IDLE;
    endproperty
    a_dataEnd: assert property (p_dataEnd) else $error("data length");

    property p_zeroRun;
        @(posedge spiClk) disable iff (rstLink)
        !csN && !mosi && zeroCnt_q == ZERO_RUN - 6'h01
            |=> state_q == L_IDLE && zeroCnt_q == 6'h00;
    endproperty
    a_zeroRun: assert property (p_zeroRun) else $error("no recovery");

    // Register side checks
    property p_eocPulse;
        @(posedge sys_clk) disable iff (srst)
        eocN && !(csRise && clrPend_q)
            |=> !eocN && resHigh_q == $past(convSample[19:4]);
    endproperty
    a_eocPulse: assert property (p_eocPulse) else $error("eoc result");

    property p_readOnly;
        @(posedge sys_clk) disable iff (srst)
        wrEvt && !regIsWritable(evt_q.addr) && !(csRise && clrPend_q)
            |=> $stable(control_q) && $stable(upper_q) && $stable(display_q);
    endproperty
    a_readOnly: assert property (p_readOnly) else $error("ro written");

    property p_readyClr;
        @(posedge sys_clk) disable iff (srst)
        doneEvt && evt_q.addr == ADDR_RESULT_HIGH && !eocN
            |=> !flags_q.ready;
    endproperty
    a_readyClr: assert property (p_readyClr) else $error("ready stuck");

    property p_signHold;
        @(posedge sys_clk) disable iff (srst)
        flags_q.sign && !statusDone && !(csRise && clrPend_q)
            |=> flags_q.sign;
    endproperty
    a_signHold: assert property (p_signHold) else $error("sign lost");

    property p_clearAll;
        @(posedge sys_clk) disable iff (srst)
        csRise && clrPend_q |=> control_q == CTRL_RST && flags_q == '0;
    endproperty
    a_clearAll: assert property (p_clearAll) else $error("no clear");

    property p_readCover;
        @(posedge sys_clk) disable iff (srst)
        doneEvt && evt_q.addr == ADDR_STATUS;
    endproperty
    c_readCover: cover property (p_readCover);

    property p_writeCover;
        @(posedge sys_clk) disable iff (srst)
        wrEvt && evt_q.addr == ADDR_CONTROL;
    endproperty
    c_writeCover: cover property (p_writeCover);

    property p_zeroCover;
        @(posedge spiClk) disable iff (rstLink)
        state_q != L_IDLE && zeroCnt_q == ZERO_RUN - 6'h01 && !mosi;
    endproperty
    c_zeroCover: cover property (p_zeroCover);
endmodule

// >>> verification/mas_host_model.sv
// Host serial master model for the register port link
`timescale 1ns/100ps
module mas_host_model
(
    output logic spiClk,
    output logic csN,
    output logic mosi,
    input wire logic dout
);
    localparam int HALF = 40;

    initial
    begin
        spiClk = 1'b0;
        csN = 1'b1;
        mosi = 1'b0;
    end

    // Clocks with chip select high, only while reset settles
    task automatic idleClocks(input int n);
        for (int i = 0; i < n; i++)
        begin
            #HALF spiClk = 1'b1;
            #HALF spiClk = 1'b0;
        end
    endtask

    // Data set after the falling edge, read bit taken before the rise
    task automatic shift(input logic [31:0] v, input int n,
        output logic [31:0] r);
        r = '0;
        for (int i = n - 1; i >= 0; i--)
        begin
            mosi = v[i];
            #HALF r = {r[30:0], dout};
            spiClk = 1'b1;
            #HALF spiClk = 1'b0;
        end
    endtask

    // One command and its data phase; command bit 0 sent as one
    task automatic frame(input logic rd, input logic [4:0] a,
        input logic [15:0] w, input int n, input int lz,
        output logic [15:0] q);
        logic [31:0] r;
        csN = 1'b0;
        #HALF;
        shift(({24'h0000_00, 1'b1, rd, a, 1'b1} << n) | w, n + 8 + lz, r);
        csN = 1'b1;
        mosi = ~mosi;
        q = (n == 16) ? r[15:0] : {8'h00, r[7:0]};
        #HALF;
    endtask

    // Abandons a command midway, then clears framing with zeros
    task automatic abortAndRecover();
        logic [31:0] r;
        csN = 1'b0;
        #HALF;
        shift(32'h0000_0005, 3, r);
        csN = 1'b1;
        #HALF;
        csN = 1'b0;
        #HALF;
        shift(32'h0000_0000, 32, r);
        csN = 1'b1;
        mosi = ~mosi;
        #HALF;
    endtask
endmodule

// >>> verification/tb_meter_adc_serial_register_port.sv
// Self-checking bench for the meter converter serial register port
`timescale 1ns/100ps
module tb_meter_adc_serial_register_port;
    import mas_pkg::*;
    localparam int PERIOD = 4000;
    localparam int W [12] = '{8, 16, 16, 16, 16, 16, 8, 16, 16, 16, 16, 8};
    localparam logic [15:0] RV [12] = '{BYTE_RST, CTRL_RST, UPPER_RST,
        LOWER_RST, WORD_RST, WORD_RST, WORD_RST, WORD_RST, WORD_RST,
        WORD_RST, WORD_RST, WORD_RST};
    logic sys_clk = 1'b0;
    logic srst;
    logic spiClk;
    logic csN;
    logic mosi;
    logic dout;
    logic doutOe;
    logic eocN;
    logic [19:0] convSample;
    logic batterySenseIn;
    logic [15:0] controlOut;
    logic [15:0] d;
    int miscompares = 0;
    int samplesChecked = 0;
    int cyc;

    always #5 sys_clk = ~sys_clk;

    mas_serial_port #(.EocPeriodCyc(PERIOD), .BattMonitor(1'b1)) dut
    (
        .sys_clk(sys_clk),
        .srst(srst),
        .spiClk(spiClk),
        .csN(csN),
        .mosi(mosi),
        .dout(dout),
        .doutOe(doutOe),
        .eocN(eocN),
        .convSample(convSample),
        .batterySenseIn(batterySenseIn),
        .controlOut(controlOut)
    );

    mas_host_model host
    (
        .spiClk(spiClk),
        .csN(csN),
        .mosi(mosi),
        .dout(dout)
    );

    function automatic logic [4:0] adr(input int i);
        return (i < 11) ? 5'(i) : 5'h14;
    endfunction

    function automatic logic [15:0] pat(input int i);
        logic [15:0] p;
        p = {8'hA5 ^ 8'(i), 8'h42 + 8'(i)};
        return (W[i] == 8) ? {8'h00, p[7:0]} : p;
    endfunction

    task automatic wrapUp();
        $display("checked %0d mismatches %0d", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samplesChecked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] w, input int n);
        logic [15:0] q;
        host.frame(1'b0, a, w, n, 0, q);
    endtask

    task automatic rdChk(input logic [4:0] a, input int n,
        input logic [15:0] exp);
        logic [15:0] q;
        host.frame(1'b1, a, 16'h0000, n, 0, q);
        chk(q, exp);
    endtask

    task automatic waitEoc(output int n);
        n = 0;
        for (int i = 1; i <= 5000; i++)
        begin
            @(posedge sys_clk);
            #1;
            if (eocN === 1'b1)
            begin
                n = i;
                return;
            end
        end
        miscompares++;
        $display("FAIL %0t no conversion pulse", $time);
        wrapUp();
    endtask

    initial
    begin
        srst = 1'b1;
        convSample = 20'h0_0000;
        batterySenseIn = 1'b0;
        host.idleClocks(3);
        repeat (10) @(negedge sys_clk);
        srst = 1'b0;
        host.idleClocks(4);
        chk({15'h0000, doutOe}, 16'h0000);
        host.csN = 1'b0;
        #1 chk({15'h0000, doutOe}, 16'h0001);
        host.csN = 1'b1;
        #40;
        for (int i = 0; i < 12; i++)
            rdChk(adr(i), W[i], RV[i]);
        rdChk(5'h0B, 8, 16'h0000);
        rdChk(5'h1F, 8, 16'h0000);
        $display("test reset values done");
        host.frame(1'b0, ADDR_CONTROL, pat(1), 16, 5, d);
        for (int i = 2; i < 10; i++)
            if (i != 8)
                wr(adr(i), pat(i), W[i]);
        for (int i = 1; i < 10; i++)
            if (i != 8)
                rdChk(adr(i), W[i], pat(i));
        chk(controlOut, pat(1));
        $display("test write readback done");
        wr(ADDR_RESULT_HIGH, 16'hFFFF, 16);
        wr(ADDR_PEAK, 16'hFFFF, 16);
        wr(ADDR_RESULT_LOW, 16'h00FF, 8);
        rdChk(ADDR_RESULT_HIGH, 16, 16'h0000);
        rdChk(ADDR_PEAK, 16, 16'h0000);
        rdChk(ADDR_RESULT_LOW, 8, 16'h0000);
        host.abortAndRecover();
        rdChk(ADDR_CONTROL, 16, pat(1));
        $display("test read-only and recovery done");
        wr(ADDR_UPPER, 16'hFFF0, 16);
        wr(ADDR_LOWER, 16'h0000, 16);
        @(negedge sys_clk);
        convSample = 20'hF_FF30;
        batterySenseIn = 1'b1;
        waitEoc(cyc);
        repeat (2) @(negedge sys_clk);
        convSample = 20'h0_1005;
        batterySenseIn = 1'b0;
        waitEoc(cyc);
        chk(16'(cyc), 16'(PERIOD - 1));
        rdChk(ADDR_STATUS, 8, 16'h00F8);
        rdChk(ADDR_STATUS, 8, 16'h0048);
        rdChk(ADDR_RESULT_HIGH, 16, 16'h0100);
        rdChk(ADDR_RESULT_LOW, 8, 16'h0005);
        rdChk(ADDR_PEAK, 16, 16'h0100);
        rdChk(ADDR_STATUS, 8, 16'h0040);
        $display("test conversion flags done");
        wr(ADDR_CONTROL, 16'h0010, 16);
        rdChk(ADDR_UPPER, 16, 16'h4E1F);
        rdChk(ADDR_CONTROL, 16, 16'h0001);
        chk(controlOut, 16'h0001);
        $display("test clear all done");
        wrapUp();
    end
endmodule
